// ==== rtl/tts_pkg.sv ====
// Constants, types and register map of the turn-off test sequencer
//==========================================================================
// Functional notes
// - One-shot press: clamp up, external gate on
// - Zero on-time holds armed state forever
// - Test starts about 2 s after release
// - Forward drive and internal supply start together
// - Forward ends on time or limit; reverse follows
// - One-shot reverse start drops all supplies
// - Continuous mode repeats at about 15 Hz
// - Continuous keeps clamp and external gate on
// - Continuous internal supply only during forward
// - Breakdown fires protection, drops supplies, halts
// - Breakdown lights lamp, bumps tally once
// - Seven-bit tally wraps after 63 to 00
// - Reset button clears the tally
// - Trigger pulse at each forward and reverse start
// - Breakdown raises the service request line
// - Current limit shortens stored on-time
package tts_pkg;

   //==========================================================================
   // Timing
   localparam int CLK_HZ        = 100_000_000;
   localparam int CLK_NS        = 10;
   localparam int START_DELAY_S = 2;
   localparam int START_CYC     = START_DELAY_S * CLK_HZ;
   localparam int REPEAT_HZ     = 15;
   localparam int REPEAT_CYC    = CLK_HZ / REPEAT_HZ;
   localparam int US_NS         = 1000;
   localparam int US_CYC        = US_NS / CLK_NS;

   //==========================================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] OFF_CTRL     = 8'h00;
   localparam logic [7:0] OFF_ONTIME   = 8'h04;
   localparam logic [7:0] OFF_OFFTIME  = 8'h08;
   localparam logic [7:0] OFF_STATUS   = 8'h0C;
   localparam logic [7:0] OFF_TALLY    = 8'h10;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h18;

   //==========================================================================
   // Fields and reset values
   localparam int         CTRL_SHOT_BIT = 0;
   localparam int         IRQ_BRK_BIT   = 0;
   localparam int         IRQ_DONE_BIT  = 1;
   localparam int         IRQ_LIMIT_BIT = 2;
   localparam logic [7:0] ONTIME_RST    = 8'h00;
   localparam logic [7:0] OFFTIME_RST   = 8'h0A;
   localparam logic [2:0] IRQ_MASK_RST  = 3'h0;
   localparam logic [6:0] TALLY_MAX     = 7'h3F;

   //==========================================================================
   // Types
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_ARMED = 3'h1,
      ST_FWD   = 3'h2,
      ST_REV   = 3'h3,
      ST_GAP   = 3'h4,
      ST_HALT  = 3'h5
   } tts_state_t;

   typedef struct packed {
      logic clampEn;
      logic intSupplyEn;
      logic extSupplyGate;
      logic fwdDrive;
      logic revDrive;
      logic protectFire;
   } tts_drive_t;

endpackage : tts_pkg

// ==== rtl/tts_sequencer.sv ====
// Turn-off test sequencer with APB register access
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module tts_sequencer #(
   parameter int START_CYC  = tts_pkg::START_CYC,
   parameter int REPEAT_CYC = tts_pkg::REPEAT_CYC
) (
   input  wire logic              clk_sys,
   input  wire logic              rst_b,
   input  wire logic [7:0]        paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              oneShotBtn,
   input  wire logic              contBtn,
   input  wire logic              tallyResetBtn,
   input  wire logic              curLimitHit,
   input  wire logic              breakdownDet,
   output tts_pkg::tts_drive_t    driveOut,
   output logic                   fwdTrig,
   output logic                   revTrig,
   output logic                   failureLamp,
   output logic                   srqOut,
   output logic      [6:0]        tallyCount,
   output logic                   irq
);

   //==========================================================================
   // Declarations
   tts_pkg::tts_state_t state_reg, state_next;
   logic        cont_reg, cont_next;
   logic [31:0] waitCnt_reg;
   logic [7:0]  usCnt_reg;
   logic [6:0]  divCnt_reg;
   logic        usTick;
   logic        shotPrev_reg, contPrev_reg;
   logic        shotPress, contPress, swShot;
   logic [7:0]  onTime_reg, offTime_reg;
   logic [2:0]  irqStat_reg, irqStat_next, irqMask_reg;
   logic        apbAccess, apbDone, apbWrite, unmapped;
   logic [31:0] rdData;
   logic        testing, fwdEnd, limitEnd, breakEvt, doneEvt;

   // Floor a duration at one microsecond so a zero never stalls a phase
   function automatic logic [7:0] atLeastOne(input logic [7:0] v);
      atLeastOne = (v == 8'h00) ? 8'h01 : v;
   endfunction : atLeastOne

   //==========================================================================
   // APB slave: one wait state so read data comes from a flop
   assign apbAccess = psel & penable;
   assign apbDone   = apbAccess & pready;
   assign apbWrite  = apbDone & pwrite & ~unmapped;

   // Address decode
   always_comb begin
      unmapped = 1'b0;
      rdData   = 32'h0000_0000;
      unique case (paddr)
         tts_pkg::OFF_CTRL:     rdData = 32'h0000_0000;
         tts_pkg::OFF_ONTIME:   rdData = {24'h00_0000, onTime_reg};
         tts_pkg::OFF_OFFTIME:  rdData = {24'h00_0000, offTime_reg};
         tts_pkg::OFF_STATUS:   rdData = {27'h000_0000, failureLamp, cont_reg, state_reg};
         tts_pkg::OFF_TALLY:    rdData = {25'h000_0000, tallyCount};
         tts_pkg::OFF_IRQ_STAT: rdData = {29'h0000_0000, irqStat_reg};
         tts_pkg::OFF_IRQ_MASK: rdData = {29'h0000_0000, irqMask_reg};
         default:               unmapped = 1'b1;
      endcase
   end

   // Ready, read data and error are captured in the first access cycle
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= apbAccess & ~pready;
         pslverr <= apbAccess & ~pready & unmapped;
         if (apbAccess && !pready) begin
            prdata <= pwrite ? 32'h0000_0000 : rdData;
         end
      end
   end

   // Writable settings; a current-limit cut overrides a same-cycle write
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         onTime_reg  <= tts_pkg::ONTIME_RST;
         offTime_reg <= tts_pkg::OFFTIME_RST;
         irqMask_reg <= tts_pkg::IRQ_MASK_RST;
      end else begin
         if (limitEnd) begin
            onTime_reg <= atLeastOne(usCnt_reg);
         end else if (apbWrite && paddr == tts_pkg::OFF_ONTIME) begin
            onTime_reg <= pwdata[7:0];
         end
         if (apbWrite && paddr == tts_pkg::OFF_OFFTIME) begin
            offTime_reg <= pwdata[7:0];
         end
         if (apbWrite && paddr == tts_pkg::OFF_IRQ_MASK) begin
            irqMask_reg <= pwdata[2:0];
         end
      end
   end

   assign swShot = apbWrite & (paddr == tts_pkg::OFF_CTRL) & pwdata[tts_pkg::CTRL_SHOT_BIT];

   //==========================================================================
   // Button edges and microsecond tick
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         shotPrev_reg <= 1'b0;
         contPrev_reg <= 1'b0;
      end else begin
         shotPrev_reg <= oneShotBtn;
         contPrev_reg <= contBtn;
      end
   end

   assign shotPress = (oneShotBtn & ~shotPrev_reg) | swShot;
   assign contPress = contBtn & ~contPrev_reg;

   // Free-running divider; phase error is below one microsecond
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         divCnt_reg <= 7'h00;
      end else if (usTick) begin
         divCnt_reg <= 7'h00;
      end else begin
         divCnt_reg <= divCnt_reg + 7'h01;
      end
   end

   assign usTick = (divCnt_reg == 7'(tts_pkg::US_CYC - 1));

   //==========================================================================
   // Sequencer
   assign testing  = (state_reg == tts_pkg::ST_ARMED) || (state_reg == tts_pkg::ST_FWD) ||
                     (state_reg == tts_pkg::ST_REV) || (state_reg == tts_pkg::ST_GAP);
   assign limitEnd = (state_reg == tts_pkg::ST_FWD) && curLimitHit && !breakdownDet &&
                     (usCnt_reg < onTime_reg) && !shotPress && !contPress;
   assign fwdEnd   = (usCnt_reg >= onTime_reg) || curLimitHit;
   assign breakEvt = testing && breakdownDet;
   assign doneEvt  = (state_reg == tts_pkg::ST_REV) && (state_next == tts_pkg::ST_IDLE);

   // Breakdown outranks button presses, which outrank the test sequence
   always_comb begin
      state_next = state_reg;
      cont_next  = cont_reg;
      if (breakEvt) begin
         state_next = tts_pkg::ST_HALT;
      end else if (contPress) begin
         state_next = tts_pkg::ST_GAP;
         cont_next  = 1'b1;
      end else if (shotPress) begin
         state_next = tts_pkg::ST_ARMED;
         cont_next  = 1'b0;
      end else begin
         unique case (state_reg)
            tts_pkg::ST_IDLE, tts_pkg::ST_HALT: state_next = state_reg;
            tts_pkg::ST_ARMED: begin
               if (onTime_reg != 8'h00 && !oneShotBtn &&
                   waitCnt_reg >= 32'(START_CYC - 1)) begin
                  state_next = tts_pkg::ST_FWD;
               end
            end
            tts_pkg::ST_FWD: begin
               if (fwdEnd) begin
                  state_next = tts_pkg::ST_REV;
               end
            end
            tts_pkg::ST_REV: begin
               if (usCnt_reg >= atLeastOne(offTime_reg)) begin
                  state_next = cont_reg ? tts_pkg::ST_GAP : tts_pkg::ST_IDLE;
               end
            end
            tts_pkg::ST_GAP: begin
               if (onTime_reg != 8'h00 && waitCnt_reg >= 32'(REPEAT_CYC - 1)) begin
                  state_next = tts_pkg::ST_FWD;
               end
            end
            default: state_next = tts_pkg::ST_IDLE;
         endcase
      end
   end

   // State and mode
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= tts_pkg::ST_IDLE;
         cont_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         cont_reg  <= cont_next;
      end
   end

   // Cycle counter: from release in armed, from forward start when repeating
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         waitCnt_reg <= 32'h0000_0000;
      end else if ((state_next == tts_pkg::ST_ARMED && (oneShotBtn || swShot)) ||
                   (state_next != state_reg && (state_next == tts_pkg::ST_ARMED ||
                    state_next == tts_pkg::ST_FWD || state_reg == tts_pkg::ST_HALT ||
                    state_reg == tts_pkg::ST_IDLE))) begin
         waitCnt_reg <= 32'h0000_0000;
      end else if (waitCnt_reg != 32'hFFFF_FFFF) begin
         waitCnt_reg <= waitCnt_reg + 32'h0000_0001;
      end
   end

   // Pulse-width counter in microseconds, restarted at each phase change
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         usCnt_reg <= 8'h00;
      end else if (state_next != state_reg) begin
         usCnt_reg <= 8'h00;
      end else if (usTick && usCnt_reg != 8'hFF) begin
         usCnt_reg <= usCnt_reg + 8'h01;
      end
   end

   //==========================================================================
   // Drive outputs registered from the next state so they change with it
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         driveOut <= '0;
         fwdTrig  <= 1'b0;
         revTrig  <= 1'b0;
      end else begin
         driveOut.clampEn       <= (state_next == tts_pkg::ST_ARMED) ||
                                   (state_next == tts_pkg::ST_FWD) ||
                                   (cont_next && (state_next == tts_pkg::ST_REV ||
                                    state_next == tts_pkg::ST_GAP));
         driveOut.extSupplyGate <= (state_next == tts_pkg::ST_ARMED) ||
                                   (state_next == tts_pkg::ST_FWD) ||
                                   (cont_next && (state_next == tts_pkg::ST_REV ||
                                    state_next == tts_pkg::ST_GAP));
         driveOut.intSupplyEn   <= (state_next == tts_pkg::ST_FWD);
         driveOut.fwdDrive      <= (state_next == tts_pkg::ST_FWD);
         driveOut.revDrive      <= (state_next == tts_pkg::ST_REV);
         driveOut.protectFire   <= (state_next == tts_pkg::ST_HALT);
         fwdTrig <= (state_next == tts_pkg::ST_FWD) && (state_reg != tts_pkg::ST_FWD);
         revTrig <= (state_next == tts_pkg::ST_REV) && (state_reg != tts_pkg::ST_REV);
      end
   end

   //==========================================================================
   // Failure reporting: lamp and service request last until a new start
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         failureLamp <= 1'b0;
         srqOut      <= 1'b0;
      end else if (breakEvt) begin
         failureLamp <= 1'b1;
         srqOut      <= 1'b1;
      end else if (shotPress || contPress) begin
         failureLamp <= 1'b0;
         srqOut      <= 1'b0;
      end
   end

   // Tally; a breakdown coinciding with the reset button still counts
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tallyCount <= 7'h00;
      end else if (tallyResetBtn) begin
         tallyCount <= breakEvt ? 7'h01 : 7'h00;
      end else if (breakEvt) begin
         tallyCount <= (tallyCount == tts_pkg::TALLY_MAX) ? 7'h00 :
                       tallyCount + 7'h01;
      end
   end

   //==========================================================================
   // Interrupts: sticky, cleared by reading, new events win over the clear
   always_comb begin
      irqStat_next = irqStat_reg;
      if (apbDone && !pwrite && paddr == tts_pkg::OFF_IRQ_STAT) begin
         irqStat_next = 3'h0;
      end
      irqStat_next[tts_pkg::IRQ_BRK_BIT]   = irqStat_next[tts_pkg::IRQ_BRK_BIT] | breakEvt;
      irqStat_next[tts_pkg::IRQ_DONE_BIT]  = irqStat_next[tts_pkg::IRQ_DONE_BIT] | doneEvt;
      irqStat_next[tts_pkg::IRQ_LIMIT_BIT] = irqStat_next[tts_pkg::IRQ_LIMIT_BIT] | limitEnd;
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         irqStat_reg <= 3'h0;
         irq         <= 1'b0;
      end else begin
         irqStat_reg <= irqStat_next;
         irq         <= |(irqStat_next & irqMask_reg);
      end
   end

   //==========================================================================
   // Assertions
   a_fwd_trig_edge: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(driveOut.fwdDrive) |-> fwdTrig && driveOut.intSupplyEn ##1 !fwdTrig)
      else $error("forward start without single trigger pulse");

   a_rev_trig_edge: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(driveOut.revDrive) |-> revTrig ##1 !revTrig)
      else $error("reverse start without single trigger pulse");

   a_int_supply_fwd: assert property (@(posedge clk_sys) disable iff (!rst_b)
      driveOut.intSupplyEn |-> driveOut.fwdDrive)
      else $error("internal supply on outside forward pulse");

   a_halt_all_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
      breakEvt |=> driveOut.protectFire && !driveOut.clampEn && !driveOut.intSupplyEn &&
                   !driveOut.extSupplyGate && !driveOut.fwdDrive && !driveOut.revDrive)
      else $error("supplies not dropped after breakdown");

   a_tally_wrap: assert property (@(posedge clk_sys) disable iff (!rst_b)
      breakEvt && !tallyResetBtn && tallyCount == 7'h3F |=> tallyCount == 7'h00)
      else $error("tally did not wrap from 63 to 0");

   a_tally_step: assert property (@(posedge clk_sys) disable iff (!rst_b)
      breakEvt && !tallyResetBtn && tallyCount != 7'h3F
      |=> tallyCount == $past(tallyCount) + 7'h01 && failureLamp && srqOut)
      else $error("breakdown not counted or reported");

   a_zero_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
      state_reg == tts_pkg::ST_ARMED && onTime_reg == 8'h00 && !breakdownDet &&
      !shotPress && !contPress |=> state_reg == tts_pkg::ST_ARMED)
      else $error("armed state left with zero on-time");

   a_cont_supplies: assert property (@(posedge clk_sys) disable iff (!rst_b)
      cont_reg && (state_reg == tts_pkg::ST_GAP || state_reg == tts_pkg::ST_REV)
      |-> driveOut.clampEn && driveOut.extSupplyGate)
      else $error("clamp or gate dropped in continuous mode");

   a_shot_rev_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
      driveOut.revDrive && !cont_reg |-> !driveOut.clampEn && !driveOut.extSupplyGate)
      else $error("supplies left on during one-shot reverse");

   a_limit_shorten: assert property (@(posedge clk_sys) disable iff (!rst_b)
      limitEnd |=> onTime_reg == atLeastOne($past(usCnt_reg)) && driveOut.revDrive)
      else $error("current limit did not shorten on-time");

   a_tally_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
      tallyResetBtn && !breakEvt |=> tallyCount == 7'h00)
      else $error("tally not cleared by reset button");

endmodule : tts_sequencer

// ==== tb/tts_partner.sv ====
// Far-side model: current-limit and breakdown sensing of the drive stage
`timescale 1ns/1ps
module tts_partner (
   input  wire logic                clk_sys,
   input  wire logic                rst_b,
   input  wire tts_pkg::tts_drive_t driveOut,
   input  wire logic [15:0]         limitAt,
   input  wire logic                brkOnRev,
   input  wire logic                brkOnClamp,
   output logic                     curLimitHit,
   output logic                     breakdownDet
);
   logic [15:0] fwdCnt_reg;

   //==========================================================================
   // Forward-pulse age; load current builds only while forward drive is on
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         fwdCnt_reg <= 16'h0000;
      end else if (driveOut.fwdDrive) begin
         fwdCnt_reg <= fwdCnt_reg + 16'h0001;
      end else begin
         fwdCnt_reg <= 16'h0000;
      end
   end

   //==========================================================================
   // Sense lines; limit holds until forward drive ends, as real current would
   assign curLimitHit  = driveOut.fwdDrive && (limitAt != 16'h0000) && (fwdCnt_reg >= limitAt);
   // Collapse only shows while the stage is energised, so it drops after protection fires
   assign breakdownDet = (brkOnRev && driveOut.revDrive) || (brkOnClamp && driveOut.clampEn);
endmodule : tts_partner

// ==== tb/testbench.sv ====
// Self-checking bench for the turn-off test sequencer
`timescale 1ns/1ps
module testbench;
   localparam int START_N  = 50;
   localparam int REPEAT_N = 1000;
   logic                clk_sys, rst_b, psel, penable, pwrite, pready, pslverr;
   logic [7:0]          paddr;
   logic [31:0]         pwdata, prdata, q;
   logic                oneShotBtn, contBtn, tallyResetBtn, curLimitHit, breakdownDet;
   tts_pkg::tts_drive_t driveOut;
   logic                fwdTrig, revTrig, failureLamp, srqOut, irq, e;
   logic [6:0]          tallyCount;
   logic [15:0]         limitAt;
   logic                brkOnRev, brkOnClamp;
   int                  fails, checkCount, a, b, c;

   tts_sequencer #(.START_CYC(START_N), .REPEAT_CYC(REPEAT_N)) tts_sequencer_inst (
      .clk_sys(clk_sys), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .oneShotBtn(oneShotBtn), .contBtn(contBtn), .tallyResetBtn(tallyResetBtn),
      .curLimitHit(curLimitHit), .breakdownDet(breakdownDet), .driveOut(driveOut),
      .fwdTrig(fwdTrig), .revTrig(revTrig), .failureLamp(failureLamp), .srqOut(srqOut),
      .tallyCount(tallyCount), .irq(irq));
   tts_partner tts_partner_inst (
      .clk_sys(clk_sys), .rst_b(rst_b), .driveOut(driveOut), .limitAt(limitAt),
      .brkOnRev(brkOnRev), .brkOnClamp(brkOnClamp), .curLimitHit(curLimitHit),
      .breakdownDet(breakdownDet));

   //==========================================================================
   // Clock and watchdog; whole run is about 10k cycles, limit is 50k
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      #500_000;
      fails++;
      $display("MISMATCH watchdog expected finish seen hang");
      stop_test();
   end

   //==========================================================================
   // Reporting
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checkCount, fails);
      if (fails == 0 && checkCount > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : stop_test
   task automatic chk(input string what, input logic [31:0] ex, input logic [31:0] got);
      checkCount++;
      if (got !== ex) begin
         fails++;
         $display("MISMATCH %s expected %0h seen %0h", what, ex, got);
      end
   endtask : chk
   task automatic chk_in(input string what, input int lo, input int hi, input int got);
      checkCount++;
      if (got < lo || got > hi) begin
         fails++;
         $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask : chk_in

   //==========================================================================
   // APB master; holds the request until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= ad;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) chk("pready", 1, 0);
   endtask : apb
   task automatic press(input logic os, input logic ct);
      @(posedge clk_sys);
      oneShotBtn <= os;
      contBtn    <= ct;
      repeat (3) @(posedge clk_sys);
      oneShotBtn <= 1'b0;
      contBtn    <= 1'b0;
   endtask : press
   // Counts edges until a trigger pulse; samples after the edge has settled
   task automatic wait_trig(input logic rv, output int n);
      n = 0;
      do begin
         @(posedge clk_sys);
         #1;
         n++;
      end while ((rv ? revTrig : fwdTrig) !== 1'b1 && n < 5000);
      if (n >= 5000) chk("trigger", 1, 0);
   endtask : wait_trig

   //==========================================================================
   // Scenarios
   task automatic t_reset();
      apb(0, tts_pkg::OFF_ONTIME, 0);
      chk("onTime", tts_pkg::ONTIME_RST, q);
      apb(0, tts_pkg::OFF_OFFTIME, 0);
      chk("offTime", tts_pkg::OFFTIME_RST, q);
      apb(0, 8'h1C, 0);
      chk("unmapped err", 1, e);
      chk("tally", 0, tallyCount);
   endtask : t_reset
   task automatic t_zero_hold();
      apb(1, tts_pkg::OFF_IRQ_MASK, 32'h7);
      press(1, 0);
      repeat (START_N + 400) @(posedge clk_sys);
      #1;
      chk("armed drive", 6'b101000, driveOut);
      apb(0, tts_pkg::OFF_STATUS, 0);
      chk("armed state", 1, q[2:0]);
   endtask : t_zero_hold
   task automatic t_single();
      apb(1, tts_pkg::OFF_ONTIME, 32'h2);
      apb(1, tts_pkg::OFF_OFFTIME, 32'h2);
      repeat (2000) @(posedge clk_sys);
      apb(0, tts_pkg::OFF_IRQ_STAT, 0);
      press(1, 0);
      wait_trig(0, a);
      chk_in("start delay", START_N - 1, START_N + 3, a);
      chk("fwd drive", 6'b111100, driveOut);
      wait_trig(1, b);
      chk_in("fwd len", 100, 302, b);
      chk("rev drive", 6'b000010, driveOut);
      repeat (400) @(posedge clk_sys);
      #1;
      chk("done irq", 1, irq);
      apb(0, tts_pkg::OFF_IRQ_STAT, 0);
      chk("done bit", 1, q[tts_pkg::IRQ_DONE_BIT]);
      @(posedge clk_sys);
      #1;
      chk("irq cleared", 0, irq);
   endtask : t_single
   task automatic t_limit();
      apb(1, tts_pkg::OFF_ONTIME, 32'hA);
      limitAt <= 16'd150;
      press(1, 0);
      wait_trig(0, a);
      wait_trig(1, b);
      chk_in("limited len", 148, 154, b);
      limitAt <= 16'h0000;
      apb(0, tts_pkg::OFF_ONTIME, 0);
      chk_in("shortened onTime", 1, 2, q);
      apb(0, tts_pkg::OFF_IRQ_STAT, 0);
      chk("limit bit", 1, q[tts_pkg::IRQ_LIMIT_BIT]);
   endtask : t_limit
   task automatic t_cont();
      apb(1, tts_pkg::OFF_ONTIME, 32'h2);
      press(0, 1);
      wait_trig(0, a);
      wait_trig(1, b);
      chk("cont rev", 6'b101010, driveOut);
      repeat (300) @(posedge clk_sys);
      #1;
      chk("cont gap", 6'b101000, driveOut);
      wait_trig(0, c);
      chk_in("repeat period", REPEAT_N - 1, REPEAT_N + 1, b + c + 300);
      brkOnRev <= 1'b1;
      wait_trig(1, a);
      repeat (2) @(posedge clk_sys);
      #1;
      chk("halt drive", 6'b000001, driveOut);
      chk("lamp", 1, failureLamp);
      chk("srq", 1, srqOut);
      chk("tally one", 1, tallyCount);
      brkOnRev <= 1'b0;
      repeat (2000) @(posedge clk_sys);
      #1;
      chk("still halted", 6'b000001, driveOut);
      apb(0, tts_pkg::OFF_IRQ_STAT, 0);
      chk("brk bit", 1, q[tts_pkg::IRQ_BRK_BIT]);
   endtask : t_cont
   task automatic t_tally();
      brkOnClamp <= 1'b1;
      for (int i = 0; i < 62; i++) begin
         press(0, 1);
         repeat (4) @(posedge clk_sys);
      end
      chk("tally top", 7'h3F, tallyCount);
      press(0, 1);
      repeat (4) @(posedge clk_sys);
      chk("tally wrap", 7'h00, tallyCount);
      press(0, 1);
      repeat (4) @(posedge clk_sys);
      tallyResetBtn <= 1'b1;
      repeat (2) @(posedge clk_sys);
      tallyResetBtn <= 1'b0;
      @(posedge clk_sys);
      chk("tally reset", 7'h00, tallyCount);
      brkOnClamp <= 1'b0;
      press(1, 0);
      repeat (4) @(posedge clk_sys);
      chk("lamp cleared", 0, failureLamp);
      chk("srq cleared", 0, srqOut);
      wait_trig(1, a);
      repeat (400) @(posedge clk_sys);
      apb(1, tts_pkg::OFF_CTRL, 32'h1);
      wait_trig(0, a);
      chk_in("soft shot delay", START_N - 1, START_N + 3, a);
   endtask : t_tally

   //==========================================================================
   // Main sequence
   initial begin
      {rst_b, psel, penable, pwrite, oneShotBtn, contBtn, tallyResetBtn} = '0;
      {brkOnRev, brkOnClamp} = '0;
      paddr   = 8'h00;
      pwdata  = 32'h0000_0000;
      limitAt = 16'h0000;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      t_reset();
      t_zero_hold();
      t_single();
      t_limit();
      t_cont();
      t_tally();
      stop_test();
   end
endmodule : testbench
